// File: common/dio_pkg.sv
/*
 Package for the digital I/O block with two pulse width modulators:
 register offsets, field positions, reset values and structs.
 Assumes a 32-bit AHB-Lite bus with single word transfers.
*/
package dio_pkg;
	localparam int DIO_NPORT = 4;
	localparam int DIO_PW = 8;
	// Port n registers sit at base + 0x10 * n
	localparam logic [7:0] DIO_PORT_STRIDE = 8'h10;
	localparam logic [7:0] DIO_OFF_DATA = 8'h00;
	localparam logic [7:0] DIO_OFF_DIR = 8'h04;
	localparam logic [7:0] DIO_OFF_POL = 8'h08;
	localparam logic [7:0] DIO_OFF_MSC = 8'h0C;
	localparam logic [7:0] DIO_OFF_PIN = 8'h40;
	localparam logic [7:0] DIO_OFF_PWM_CTL = 8'h44;
	// Modulator n registers sit at base + 0x8 * n
	localparam logic [7:0] DIO_PWM_STRIDE = 8'h08;
	localparam logic [7:0] DIO_OFF_PWM_PER = 8'h50;
	localparam logic [7:0] DIO_OFF_PWM_DUTY = 8'h54;
	localparam int DIO_MSC_SET_LSB = 0;
	localparam int DIO_MSC_CLR_LSB = 8;
	localparam int DIO_CTL_EN_LSB = 0;
	localparam int DIO_CTL_EXT_LSB = 2;
	localparam int DIO_CTL_STRAP_BIT = 8;
	localparam int DIO_PWM_W = 16;
	localparam logic [7:0] DIO_DIR_RST = 8'h00;
	localparam logic [7:0] DIO_POL_RST = 8'h00;
	localparam logic [15:0] DIO_PER_RST = 16'h0000;
	localparam logic [1:0] DIO_HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] DIO_HSIZE_WORD = 3'h2;

	typedef struct packed {
		logic [7:0] data;
		logic [7:0] dir;
		logic [7:0] pol;
	} dio_port_t;

	typedef struct packed {
		logic en;
		logic ext;
		logic [15:0] per;
		logic [15:0] duty;
	} dio_pwm_t;
endpackage

// File: hw/dio_top.sv
/*
 Digital I/O block: four byte-wide ports with direction and polarity per
 line, masked set/clear updates, pull strap, two pulse width modulators.
 Assumes an AHB-Lite master with single word transfers; pins and strap and
 the external modulator clock are asynchronous to clk.
*/
// Implementation choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/10ps
module dio_top import dio_pkg::*; (
	input wire logic clk,
	input wire logic srst,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [31:0] pin_in,
	output logic [31:0] pin_out,
	output logic [31:0] pin_oe_n,
	output logic [31:0] pull_up_en,
	output logic [31:0] pull_dn_en,
	input wire logic pull_direction_strap,
	input wire logic ext_pwm_clk,
	output logic modulated_output_a,
	output logic modulated_output_b
);
	dio_port_t port_r [DIO_NPORT];
	dio_port_t port_nxt [DIO_NPORT];
	dio_pwm_t pwm_r [2];
	dio_pwm_t pwm_nxt [2];
	logic [15:0] cnt_r [2];
	logic [15:0] cnt_nxt [2];
	logic [1:0] pwm_q_nxt;
	logic [31:0] pin_s1_r, pin_s2_r;
	logic [2:0] pclk_sy_r;
	logic [1:0] strap_sy_r;
	logic strap_r, strap_nxt, strap_done_r;
	logic aw_r, aw_nxt;
	logic [7:0] aaddr_r, aaddr_nxt;
	logic [31:0] rdata_nxt;
	logic pclk_rise;

	function automatic logic [7:0] port_of(input logic [7:0] a);
		return {4'h0, a[7:4]};
	endfunction

	// Synchronisers; first stage feeds only the second
	always_ff @(posedge clk) begin
		pin_s1_r <= pin_in;
		pin_s2_r <= pin_s1_r;
		pclk_sy_r <= {pclk_sy_r[1:0], ext_pwm_clk};
		strap_sy_r <= {strap_sy_r[0], pull_direction_strap};
	end
	assign pclk_rise = pclk_sy_r[1] & ~pclk_sy_r[2];

	always_comb begin
		aw_nxt = 1'b0;
		aaddr_nxt = aaddr_r;
		if (hsel && hready && htrans == DIO_HTRANS_NONSEQ) begin
			aw_nxt = hwrite;
			aaddr_nxt = haddr;
		end
		strap_nxt = strap_done_r ? strap_r : strap_sy_r[1];
		for (int p = 0; p < DIO_NPORT; p++) begin
			port_nxt[p] = port_r[p];
		end
		for (int m = 0; m < 2; m++) begin
			pwm_nxt[m] = pwm_r[m];
		end
		if (aw_r) begin
			if (aaddr_r < DIO_OFF_PIN) begin
				for (int p = 0; p < DIO_NPORT; p++) begin
					if (port_of(aaddr_r) == p[7:0]) begin
						if (aaddr_r[3:0] == DIO_OFF_DATA[3:0]) begin
							// Only output bits take the value
							port_nxt[p].data = (hwdata[7:0] & port_r[p].dir)
								| (port_r[p].data & ~port_r[p].dir);
						end else if (aaddr_r[3:0] == DIO_OFF_DIR[3:0]) begin
							port_nxt[p].dir = hwdata[7:0];
						end else if (aaddr_r[3:0] == DIO_OFF_POL[3:0]) begin
							port_nxt[p].pol = hwdata[7:0];
						end else if (aaddr_r[3:0] == DIO_OFF_MSC[3:0]) begin
							// Must-on wins over must-off
							port_nxt[p].data = port_r[p].data
								& ~(hwdata[DIO_MSC_CLR_LSB +: 8] & port_r[p].dir);
							port_nxt[p].data = port_nxt[p].data
								| (hwdata[DIO_MSC_SET_LSB +: 8] & port_r[p].dir);
						end
					end
				end
			end else if (aaddr_r == DIO_OFF_PWM_CTL) begin
				for (int m = 0; m < 2; m++) begin
					pwm_nxt[m].en = hwdata[DIO_CTL_EN_LSB + m];
					pwm_nxt[m].ext = hwdata[DIO_CTL_EXT_LSB + m];
				end
			end else begin
				for (int m = 0; m < 2; m++) begin
					if (aaddr_r == DIO_OFF_PWM_PER + DIO_PWM_STRIDE * m[7:0]) begin
						pwm_nxt[m].per = hwdata[15:0];
					end else if (aaddr_r == DIO_OFF_PWM_DUTY + DIO_PWM_STRIDE * m[7:0]) begin
						pwm_nxt[m].duty = hwdata[15:0];
					end
				end
			end
		end
	end

	// Read data, registered at address phase
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		if (hsel && hready && htrans == DIO_HTRANS_NONSEQ && !hwrite) begin
			if (haddr < DIO_OFF_PIN) begin
				for (int p = 0; p < DIO_NPORT; p++) begin
					if (port_of(haddr) == p[7:0]) begin
						if (haddr[3:0] == DIO_OFF_DATA[3:0]) begin
							// Outputs read last written, inputs read the synchronised pin XOR polarity
							rdata_nxt[7:0] = (port_r[p].data & port_r[p].dir)
								| ((pin_s2_r[8*p +: 8] ^ port_r[p].pol) & ~port_r[p].dir);
						end else if (haddr[3:0] == DIO_OFF_DIR[3:0]) begin
							rdata_nxt[7:0] = port_r[p].dir;
						end else if (haddr[3:0] == DIO_OFF_POL[3:0]) begin
							rdata_nxt[7:0] = port_r[p].pol;
						end
					end
				end
			end else if (haddr == DIO_OFF_PIN) begin
				rdata_nxt = pin_s2_r;
			end else if (haddr == DIO_OFF_PWM_CTL) begin
				rdata_nxt[DIO_CTL_EN_LSB +: 2] = {pwm_r[1].en, pwm_r[0].en};
				rdata_nxt[DIO_CTL_EXT_LSB +: 2] = {pwm_r[1].ext, pwm_r[0].ext};
				rdata_nxt[DIO_CTL_STRAP_BIT] = strap_r;
			end else begin
				for (int m = 0; m < 2; m++) begin
					if (haddr == DIO_OFF_PWM_PER + DIO_PWM_STRIDE * m[7:0]) begin
						rdata_nxt[15:0] = pwm_r[m].per;
					end else if (haddr == DIO_OFF_PWM_DUTY + DIO_PWM_STRIDE * m[7:0]) begin
						rdata_nxt[15:0] = pwm_r[m].duty;
					end
				end
			end
		end
	end

	// Modulators: count 0..per, high while count < duty
	always_comb begin
		for (int m = 0; m < 2; m++) begin
			cnt_nxt[m] = cnt_r[m];
			pwm_q_nxt[m] = 1'b0;
			if (pwm_r[m].en) begin
				if (!pwm_r[m].ext || pclk_rise) begin
					cnt_nxt[m] = (cnt_r[m] >= pwm_r[m].per) ? 16'h0000
						: cnt_r[m] + 16'h0001;
				end
				pwm_q_nxt[m] = cnt_r[m] < pwm_r[m].duty;
			end else begin
				cnt_nxt[m] = 16'h0000;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			for (int p = 0; p < DIO_NPORT; p++) begin
				port_r[p] <= '{data: 8'h00, dir: DIO_DIR_RST, pol: DIO_POL_RST};
			end
			for (int m = 0; m < 2; m++) begin
				pwm_r[m] <= '{en: 1'b0, ext: 1'b0, per: DIO_PER_RST, duty: 16'h0000};
				cnt_r[m] <= 16'h0000;
			end
			aw_r <= 1'b0;
			aaddr_r <= 8'h00;
			hrdata <= 32'h0000_0000;
			strap_r <= 1'b1;
			strap_done_r <= 1'b0;
		end else begin
			port_r <= port_nxt;
			pwm_r <= pwm_nxt;
			cnt_r <= cnt_nxt;
			aw_r <= aw_nxt;
			aaddr_r <= aaddr_nxt;
			hrdata <= rdata_nxt;
			strap_r <= strap_nxt;
			strap_done_r <= 1'b1;
		end
	end

	// Pin drive and pull, straight from flops
	always_ff @(posedge clk) begin
		if (srst) begin
			pin_out <= 32'h0000_0000;
			pin_oe_n <= 32'hFFFF_FFFF;
			pull_up_en <= 32'h0000_0000;
			pull_dn_en <= 32'h0000_0000;
			modulated_output_a <= 1'b0;
			modulated_output_b <= 1'b0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			for (int p = 0; p < DIO_NPORT; p++) begin
				pin_out[8*p +: 8] <= port_nxt[p].data ^ port_nxt[p].pol;
				pin_oe_n[8*p +: 8] <= ~port_nxt[p].dir;
			end
			pull_up_en <= {32{strap_nxt}};
			pull_dn_en <= {32{~strap_nxt}};
			modulated_output_a <= pwm_q_nxt[0];
			modulated_output_b <= pwm_q_nxt[1];
			// Zero wait, always OKAY
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// Assertions
	inert_input_a: assert property (@(posedge clk) disable iff (srst)
		aw_r && aaddr_r == DIO_OFF_DATA && port_r[0].dir == 8'h00
		|=> $stable(port_r[0].data)) else $error("input bit changed by write");
	drive_pol_a: assert property (@(posedge clk) disable iff (srst)
		##1 pin_out[7:0] == ($past(port_nxt[0].data) ^ $past(port_nxt[0].pol)))
		else $error("pin level does not follow data and polarity");
	oe_dir_a: assert property (@(posedge clk) disable iff (srst)
		##1 pin_oe_n[15:8] == ~$past(port_nxt[1].dir)) else $error("enable mismatch");
	msc_keep_a: assert property (@(posedge clk) disable iff (srst)
		aw_r && aaddr_r == DIO_OFF_MSC && port_r[0].dir == 8'hFF
		|=> port_r[0].data == (($past(port_r[0].data) & ~$past(hwdata[15:8]))
		| $past(hwdata[7:0]))) else $error("masked update wrong");
	pwm_off_a: assert property (@(posedge clk) disable iff (srst)
		!pwm_r[0].en ##1 !pwm_r[0].en |-> !modulated_output_a)
		else $error("disabled modulator active");
	pwm_duty_a: assert property (@(posedge clk) disable iff (srst)
		pwm_r[1].en && cnt_r[1] < pwm_r[1].duty |=> modulated_output_b)
		else $error("modulator low inside duty");
	pwm_ext_a: assert property (@(posedge clk) disable iff (srst)
		pwm_r[0].en && pwm_r[0].ext && !pclk_rise && cnt_r[0] != 16'h0000
		|=> cnt_r[0] == $past(cnt_r[0])) else $error("counter moved without edge");
	pull_strap_a: assert property (@(posedge clk) disable iff (srst)
		!$past(srst) |-> (pull_up_en == ~pull_dn_en) [*2])
		else $error("pull select inconsistent");
	inert_msc_a: assert property (@(posedge clk) disable iff (srst)
		aw_r && aaddr_r == DIO_OFF_MSC && port_r[0].dir == 8'h00
		|=> $stable(port_r[0].data)) else $error("masked update hit input bit");
	strap_lock_a: assert property (@(posedge clk) disable iff (srst)
		strap_done_r |=> strap_r == $past(strap_r))
		else $error("strap changed after capture");
	pull_follow_a: assert property (@(posedge clk) disable iff (srst)
		strap_done_r |-> pull_up_en == {32{strap_r}})
		else $error("pull does not follow strap");
	read_out_a: assert property (@(posedge clk) disable iff (srst)
		hsel && hready && htrans == DIO_HTRANS_NONSEQ && !hwrite && haddr == DIO_OFF_DATA
		&& port_r[0].dir == 8'hFF |=> hrdata[7:0] == $past(port_r[0].data))
		else $error("output read not last written");
	read_in_a: assert property (@(posedge clk) disable iff (srst)
		hsel && hready && htrans == DIO_HTRANS_NONSEQ && !hwrite
		&& haddr == DIO_OFF_DATA + DIO_PORT_STRIDE && port_r[1].dir == 8'h00
		|=> hrdata[7:0] == ($past(pin_s2_r[15:8]) ^ $past(port_r[1].pol)))
		else $error("input read not polarised pin");
	whole_port_a: assert property (@(posedge clk) disable iff (srst)
		aw_r && aaddr_r == DIO_OFF_DATA + DIO_PORT_STRIDE * 8'h03
		&& port_r[3].dir == 8'hFF |=> port_r[3].data == $past(hwdata[7:0]))
		else $error("whole port write lost");
	pwm_low_a: assert property (@(posedge clk) disable iff (srst)
		pwm_r[0].en && cnt_r[0] >= pwm_r[0].duty |=> !modulated_output_a)
		else $error("modulator high outside duty");
	pwm_wrap_a: assert property (@(posedge clk) disable iff (srst)
		pwm_r[1].en && !pwm_r[1].ext && cnt_r[1] >= pwm_r[1].per |=> cnt_r[1] == 16'h0000)
		else $error("counter did not wrap at period");
	pwm_step_a: assert property (@(posedge clk) disable iff (srst)
		pwm_r[1].en && !pwm_r[1].ext && cnt_r[1] < pwm_r[1].per
		|=> cnt_r[1] == $past(cnt_r[1]) + 16'h0001)
		else $error("internal tick did not advance");
	ext_step_a: assert property (@(posedge clk) disable iff (srst)
		pwm_r[0].en && pwm_r[0].ext && pclk_rise && cnt_r[0] < pwm_r[0].per
		|=> cnt_r[0] == $past(cnt_r[0]) + 16'h0001)
		else $error("external edge did not advance");
	rise_once_a: assert property (@(posedge clk) disable iff (srst)
		pclk_rise |=> !pclk_rise)
		else $error("external edge seen twice");
	pwm_off_b_a: assert property (@(posedge clk) disable iff (srst)
		!pwm_r[1].en ##1 !pwm_r[1].en |-> !modulated_output_b)
		else $error("disabled modulator active");
	cnt_clear_a: assert property (@(posedge clk) disable iff (srst)
		!pwm_r[0].en |=> cnt_r[0] == 16'h0000)
		else $error("disabled counter not cleared");
endmodule // dio_top

// File: dv/dio_field.sv
/*
 Field devices on the 32 digital pins: each line sees the block's drive,
 else an external driver, else the selected pull.
 Assumes the testbench sets which lines it drives and to what level.
*/
`timescale 1ns/10ps
module dio_field (
	input wire logic [31:0] pin_out,
	input wire logic [31:0] pin_oe_n,
	input wire logic [31:0] pull_up_en,
	input wire logic [31:0] pull_dn_en,
	input wire logic [31:0] drive_val,
	input wire logic [31:0] drive_en,
	output logic [31:0] pin_in
);
	always_comb begin
		for (int i = 0; i < 32; i++) begin
			if (!pin_oe_n[i])
				pin_in[i] = pin_out[i];
			else if (drive_en[i])
				pin_in[i] = drive_val[i];
			else if (pull_up_en[i] || pull_dn_en[i])
				pin_in[i] = pull_up_en[i];
			// Floating line: opposite of the last drive
			else
				pin_in[i] = ~pin_out[i];
		end
	end
endmodule // dio_field

// File: dv/digital_io_ports_with_pwm_test.sv
/*
 Self-checking testbench for the digital I/O block: bus tasks, port,
 polarity, masked update, strap and modulator tests.
 Assumes a zero-wait AHB-Lite slave and the dio_field pin model.
*/
`timescale 1ns/10ps
module digital_io_ports_with_pwm_test import dio_pkg::*;;
	logic clk = 0, srst = 1, hsel = 0, hwrite = 0, strap = 1, ext = 0;
	logic [1:0] htrans = 2'h0;
	logic [7:0] haddr = 8'h00;
	logic [31:0] hwdata = 32'h0, drv = 32'h0, drv_en = 32'h0, rdv;
	logic [31:0] hrdata, pin_in, pin_out, oe_n, pu, pd;
	logic hready, hresp, pa, pb;
	int num_errors = 0, n_checks = 0, ca, cb;

	dio_top dut (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(DIO_HSIZE_WORD), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe_n(oe_n), .pull_up_en(pu), .pull_dn_en(pd),
		.pull_direction_strap(strap), .ext_pwm_clk(ext),
		.modulated_output_a(pa), .modulated_output_b(pb));
	dio_field field (.pin_out(pin_out), .pin_oe_n(oe_n), .pull_up_en(pu),
		.pull_dn_en(pd), .drive_val(drv), .drive_en(drv_en), .pin_in(pin_in));

	initial begin
		forever #25 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= DIO_HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hready !== 1'b1);
		rdv = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ahb(1'b1, a, d);
	endtask

	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
		ahb(1'b0, a, 32'h0);
		chk(nm, rdv, exp);
	endtask

	// Counts modulator high cycles, toggling the external clock every half
	task automatic run(input int n, input int half);
		ca = 0;
		cb = 0;
		for (int i = 1; i <= n; i++) begin
			@(posedge clk);
			ca += int'(pa);
			cb += int'(pb);
			if (half > 0 && i % half == 0)
				ext <= ~ext;
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge clk);
		num_errors++;
		finish_test();
	end

	initial begin
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		rd("dir0", 8'h04, 32'h0);
		rd("pol3", 8'h38, 32'h0);
		chk("oe_n", oe_n, 32'hFFFFFFFF);
		chk("mod", {30'h0, pa, pb}, 32'h0);
		chk("hresp", {31'h0, hresp}, 32'h0);
		chk("pull up", pu, 32'hFFFFFFFF);
		rd("ctl", 8'h44, 32'h100);
		$display("reset test done");
		wr(8'h00, 32'h5A);
		wr(8'h0C, 32'hFF);
		rd("in0 wr", 8'h00, 32'hFF);
		wr(8'h04, 32'hFF);
		wr(8'h00, 32'hA5);
		wr(8'h08, 32'h0F);
		rd("data0", 8'h00, 32'hA5);
		chk("pins0", {24'h0, pin_out[7:0]}, 32'hAA);
		chk("oe0", {24'h0, oe_n[7:0]}, 32'h0);
		wr(8'h0C, 32'h8002);
		rd("msc0", 8'h00, 32'h27);
		wr(8'h34, 32'hFF);
		wr(8'h30, 32'hFF);
		wr(8'h30, 32'h00);
		rd("data3", 8'h30, 32'h0);
		chk("pins3", {24'h0, pin_out[31:24]}, 32'h0);
		drv_en <= 32'hFFFFFFFF;
		drv <= 32'h00503C00;
		wr(8'h18, 32'hF0);
		rd("in1", 8'h10, 32'hCC);
		wr(8'h10, 32'hFF);
		rd("in1 wr", 8'h10, 32'hCC);
		chk("oe1", {24'h0, oe_n[15:8]}, 32'hFF);
		wr(8'h24, 32'h0F);
		wr(8'h20, 32'hFF);
		rd("mixed2", 8'h20, 32'h5F);
		wr(8'h60, 32'hFF);
		rd("unmapped", 8'h60, 32'h0);
		$display("port test done");
		wr(8'h50, 32'h3);
		wr(8'h54, 32'h2);
		wr(8'h58, 32'h4);
		wr(8'h5C, 32'h1);
		wr(8'h44, 32'h3);
		run(40, 0);
		chk("int a", ca, 32'd20);
		chk("int b", cb, 32'd8);
		wr(8'h44, 32'h7);
		run(80, 5);
		chk("ext a", {31'h0, ca >= 30 && ca <= 50}, 32'h1);
		chk("int b2", cb, 32'd16);
		run(20, 0);
		chk("ext idle", {31'h0, ca == 0 || ca == 20}, 32'h1);
		$display("modulator test done");
		strap <= 1'b0;
		srst <= 1'b1;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		rd("ctl low", 8'h44, 32'h0);
		chk("pull dn", pd, 32'hFFFFFFFF);
		$display("strap test done");
		finish_test();
	end
endmodule // digital_io_ports_with_pwm_test
